// ---- hdl/hwpdc_config_regs.sv ----
// What this block does
// - hardware_pin_setup resets to zero, so the brake pin rules and speed comes from analog.
// - the brake mode bit picks low-side brake on zero and align brake on one.
// - the align angle bit picks the last commutation angle on zero, the configured one on one.
// - brake override zero or three follows the pin, one forces braking, two forces none.
// - the speed source field picks analog, duty cycle, register or pin frequency.
// - device_setup_one loads its open fields from stored setup; fixed fields reset to zero.
// - the supply range field picks 15 V, 30 V or 60 V scaling; three is flagged invalid.
// - device_setup_two sits at offset a8 and resets to zero.
//
// The implementer's own choice: the plain strobed port.
`timescale 1ns/1ns
`default_nettype none
module hwpdc_config_regs
#(
    parameter logic [31:0] STORED_DEFAULT = 32'h00000000
)
(
    input  wire logic                        clk,
    input  wire logic                        reset,
    input  wire logic [7:0]                  addr,
    input  wire logic [31:0]                 wr_data,
    input  wire logic                        wr_en,
    input  wire logic                        rd_en,
    output logic      [31:0]                 rd_data_q,
    input  wire logic                        stored_load,
    input  wire logic [31:0]                 stored_data,
    input  wire logic                        brake_pin,
    input  wire logic                        output_option_a,
    input  wire logic                        output_option_b,
    input  wire logic                        output_option_c,
    output logic                             multi_out_q,
    output hwpdc_pkg::hwpdc_brake_ctl_t      brake_ctl_q,
    output hwpdc_pkg::hwpdc_speed_sel_t      speed_sel_q,
    output logic      [6:0]                  target_addr_q,
    output logic      [1:0]                  supply_range_select_q,
    output logic                             supply_range_valid_q,
    output logic      [31:0]                 device_setup_two_q
);

    logic [31:0] pin_setup_q;
    logic [31:0] pin_setup_d;
    logic [31:0] dev_one_q;
    logic [31:0] dev_one_d;
    logic [31:0] dev_two_d;
    logic [31:0] rd_data_d;

    logic [hwpdc_pkg::HWPDC_SYNC_STAGES-1:0] brake_sync_q;
    logic [hwpdc_pkg::HWPDC_SYNC_STAGES-1:0] brake_sync_d;
    logic                                    brake_level_q;
    logic                                    brake_level_d;

    hwpdc_pkg::hwpdc_brake_ctl_t brake_ctl_d;
    hwpdc_pkg::hwpdc_speed_sel_t speed_sel_d;
    logic                        multi_out_d;
    logic [6:0]                  target_addr_d;
    logic [1:0]                  supply_range_d;
    logic                        supply_range_valid_d;

    hwpdc_pkg::hwpdc_brake_ovr_t brake_ovr;
    hwpdc_pkg::hwpdc_speed_src_t speed_src;
    hwpdc_pkg::hwpdc_out_sel_t   out_sel;
    hwpdc_pkg::hwpdc_range_t     range_sel;
    logic                        brake_req;

    // register file: software writes, stored-setup load, read port
    always_comb
    begin
        pin_setup_d = pin_setup_q;
        dev_one_d   = dev_one_q;
        dev_two_d   = device_setup_two_q;
        rd_data_d   = hwpdc_pkg::HWPDC_READ_IDLE;
        if (stored_load)
        begin
            // open fields only; fixed fields keep their value
            dev_one_d = (dev_one_q & hwpdc_pkg::HWPDC_DEV_ONE_MASK)
                      | (stored_data & ~hwpdc_pkg::HWPDC_DEV_ONE_MASK);
        end
        if (wr_en)
        begin
            case (addr)
                // all 32 bits stored, parity and reserved included
                hwpdc_pkg::HWPDC_PIN_SETUP_OFS: pin_setup_d = wr_data;
                hwpdc_pkg::HWPDC_DEV_ONE_OFS:   dev_one_d   = wr_data;
                hwpdc_pkg::HWPDC_DEV_TWO_OFS:   dev_two_d   = wr_data;
                default:                        pin_setup_d = pin_setup_q;
            endcase
        end
        if (rd_en)
        begin
            case (addr)
                hwpdc_pkg::HWPDC_PIN_SETUP_OFS: rd_data_d = pin_setup_q;
                hwpdc_pkg::HWPDC_DEV_ONE_OFS:   rd_data_d = dev_one_q;
                hwpdc_pkg::HWPDC_DEV_TWO_OFS:   rd_data_d = device_setup_two_q;
                default:                        rd_data_d = hwpdc_pkg::HWPDC_READ_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            pin_setup_q        <= hwpdc_pkg::HWPDC_PIN_SETUP_RST;
            // fixed fields zero, open fields take the stored default
            dev_one_q          <= (STORED_DEFAULT & ~hwpdc_pkg::HWPDC_DEV_ONE_MASK)
                                | hwpdc_pkg::HWPDC_DEV_ONE_FIXED;
            device_setup_two_q <= hwpdc_pkg::HWPDC_DEV_TWO_RST;
            rd_data_q          <= hwpdc_pkg::HWPDC_READ_IDLE;
        end
        else
        begin
            pin_setup_q        <= pin_setup_d;
            dev_one_q          <= dev_one_d;
            device_setup_two_q <= dev_two_d;
            rd_data_q          <= rd_data_d;
        end
    end

    // brake pin synchroniser; level changes once stages two and three agree
    always_comb
    begin
        brake_sync_d  = {brake_sync_q[hwpdc_pkg::HWPDC_SYNC_STAGES-2:0], brake_pin};
        brake_level_d = brake_level_q;
        if (brake_sync_q[1] == brake_sync_q[2])
        begin
            brake_level_d = brake_sync_q[2];
        end
    end

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            brake_sync_q  <= '0;
            brake_level_q <= 1'b0;
        end
        else
        begin
            brake_sync_q  <= brake_sync_d;
            brake_level_q <= brake_level_d;
        end
    end

    // decode of the configuration into control outputs
    always_comb
    begin
        brake_ovr = hwpdc_pkg::hwpdc_brake_ovr_t'(
                    pin_setup_q[hwpdc_pkg::HWPDC_BRAKE_OVR_LSB +: 2]);
        speed_src = hwpdc_pkg::hwpdc_speed_src_t'(
                    pin_setup_q[hwpdc_pkg::HWPDC_SPEED_LSB +: 2]);
        out_sel   = hwpdc_pkg::hwpdc_out_sel_t'(
                    dev_one_q[hwpdc_pkg::HWPDC_OUT_SEL_LSB +: 2]);
        range_sel = hwpdc_pkg::hwpdc_range_t'(
                    dev_one_q[hwpdc_pkg::HWPDC_RANGE_LSB +: 2]);

        case (brake_ovr)
            hwpdc_pkg::HWPDC_BRK_FOLLOW_PIN: brake_req = brake_level_q;
            hwpdc_pkg::HWPDC_BRK_FORCE_ON:   brake_req = 1'b1;
            hwpdc_pkg::HWPDC_BRK_FORCE_OFF:  brake_req = 1'b0;
            hwpdc_pkg::HWPDC_BRK_PIN_ALT:    brake_req = brake_level_q;
            default:                         brake_req = brake_level_q;
        endcase

        brake_ctl_d.lowside_on = brake_req
                               & ~pin_setup_q[hwpdc_pkg::HWPDC_BRAKE_MODE_BIT];
        brake_ctl_d.align_on   = brake_req
                               & pin_setup_q[hwpdc_pkg::HWPDC_BRAKE_MODE_BIT];
        brake_ctl_d.use_config_angle = pin_setup_q[hwpdc_pkg::HWPDC_ALIGN_SEL_BIT];

        speed_sel_d.analog       = (speed_src == hwpdc_pkg::HWPDC_SPD_ANALOG);
        speed_sel_d.duty         = (speed_src == hwpdc_pkg::HWPDC_SPD_DUTY);
        speed_sel_d.reg_override = (speed_src == hwpdc_pkg::HWPDC_SPD_REG);
        speed_sel_d.freq         = (speed_src == hwpdc_pkg::HWPDC_SPD_FREQ);

        case (out_sel)
            hwpdc_pkg::HWPDC_OUT_NONE: multi_out_d = 1'b0;
            hwpdc_pkg::HWPDC_OUT_A:    multi_out_d = output_option_a;
            hwpdc_pkg::HWPDC_OUT_B:    multi_out_d = output_option_b;
            hwpdc_pkg::HWPDC_OUT_C:    multi_out_d = output_option_c;
            default:                   multi_out_d = 1'b0;
        endcase

        target_addr_d        = dev_one_q[hwpdc_pkg::HWPDC_ADDR_LSB +: 7];
        supply_range_d       = range_sel;
        supply_range_valid_d = (range_sel != hwpdc_pkg::HWPDC_RANGE_UNDF);
    end

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            brake_ctl_q           <= '0;
            speed_sel_q           <= '0;
            multi_out_q           <= 1'b0;
            target_addr_q         <= 7'h00;
            supply_range_select_q <= 2'h0;
            supply_range_valid_q  <= 1'b0;
        end
        else
        begin
            brake_ctl_q           <= brake_ctl_d;
            speed_sel_q           <= speed_sel_d;
            multi_out_q           <= multi_out_d;
            target_addr_q         <= target_addr_d;
            supply_range_select_q <= supply_range_d;
            supply_range_valid_q  <= supply_range_valid_d;
        end
    end

endmodule
`default_nettype wire

// ---- hdl/hwpdc_pkg.sv ----
`default_nettype none
package hwpdc_pkg;

    // register offsets as printed, used directly as the port address
    localparam logic [7:0]  HWPDC_PIN_SETUP_OFS  = 8'ha4;
    localparam logic [7:0]  HWPDC_DEV_ONE_OFS    = 8'ha6;
    localparam logic [7:0]  HWPDC_DEV_TWO_OFS    = 8'ha8;

    // values after reset
    localparam logic [31:0] HWPDC_PIN_SETUP_RST  = 32'h00000000;
    localparam logic [31:0] HWPDC_DEV_TWO_RST    = 32'h00000000;
    localparam logic [31:0] HWPDC_DEV_ONE_FIXED  = 32'h00000000;
    // bits of device_setup_one with a fixed reset value (31..27, 4..0)
    localparam logic [31:0] HWPDC_DEV_ONE_MASK   = 32'hf800001f;
    localparam logic [31:0] HWPDC_READ_IDLE      = 32'h00000000;

    // field positions, hardware_pin_setup
    localparam int unsigned HWPDC_SPEED_LSB      = 0;
    localparam int unsigned HWPDC_BRAKE_OVR_LSB  = 2;
    localparam int unsigned HWPDC_ALIGN_SEL_BIT  = 4;
    localparam int unsigned HWPDC_BRAKE_MODE_BIT = 5;
    // field positions, device_setup_one
    localparam int unsigned HWPDC_RANGE_LSB      = 0;
    localparam int unsigned HWPDC_ADDR_LSB       = 20;
    localparam int unsigned HWPDC_OUT_SEL_LSB    = 28;
    localparam int unsigned HWPDC_PARITY_BIT     = 31;

    localparam int unsigned HWPDC_SYNC_STAGES    = 3;

    typedef enum logic [1:0]
    {
        HWPDC_BRK_FOLLOW_PIN = 2'h0,
        HWPDC_BRK_FORCE_ON   = 2'h1,
        HWPDC_BRK_FORCE_OFF  = 2'h2,
        HWPDC_BRK_PIN_ALT    = 2'h3
    } hwpdc_brake_ovr_t;

    typedef enum logic [1:0]
    {
        HWPDC_SPD_ANALOG = 2'h0,
        HWPDC_SPD_DUTY   = 2'h1,
        HWPDC_SPD_REG    = 2'h2,
        HWPDC_SPD_FREQ   = 2'h3
    } hwpdc_speed_src_t;

    typedef enum logic [1:0]
    {
        HWPDC_OUT_NONE = 2'h0,
        HWPDC_OUT_A    = 2'h1,
        HWPDC_OUT_B    = 2'h2,
        HWPDC_OUT_C    = 2'h3
    } hwpdc_out_sel_t;

    typedef enum logic [1:0]
    {
        HWPDC_RANGE_15V  = 2'h0,
        HWPDC_RANGE_30V  = 2'h1,
        HWPDC_RANGE_60V  = 2'h2,
        HWPDC_RANGE_UNDF = 2'h3
    } hwpdc_range_t;

    typedef struct packed
    {
        logic lowside_on;
        logic align_on;
        logic use_config_angle;
    } hwpdc_brake_ctl_t;

    typedef struct packed
    {
        logic analog;
        logic duty;
        logic reg_override;
        logic freq;
    } hwpdc_speed_sel_t;

endpackage
`default_nettype wire

// ---- tb/hwpdc_regs_chk.sv ----
`timescale 1ns/1ns
`default_nettype none
module hwpdc_regs_chk
(
    input wire logic                        clk,
    input wire logic                        reset,
    input wire logic [7:0]                  addr,
    input wire logic [31:0]                 wr_data,
    input wire logic                        wr_en,
    input wire logic                        rd_en,
    input wire logic [31:0]                 rd_data_q,
    input wire hwpdc_pkg::hwpdc_speed_sel_t speed_sel_q,
    input wire logic [6:0]                  target_addr_q,
    input wire logic [1:0]                  supply_range_select_q,
    input wire logic                        supply_range_valid_q,
    input wire logic [31:0]                 device_setup_two_q
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    sequence s_wr(logic [7:0] a);
        wr_en && addr == a;
    endsequence
    sequence s_rd(logic [7:0] a);
        rd_en && addr == a;
    endsequence
    a_speed_onehot: assert property (s_wr(8'ha4) ##2 1 |->
        speed_sel_q == (4'h8 >> $past(wr_data[1:0], 2))) else $error("speed select wrong");
    a_target_addr: assert property (s_wr(8'ha6) ##2 1 |->
        target_addr_q == $past(wr_data[26:20], 2)) else $error("target address wrong");
    a_range_sel: assert property (s_wr(8'ha6) ##2 1 |->
        supply_range_select_q == $past(wr_data[1:0], 2)) else $error("range wrong");
    a_range_valid: assert property (s_wr(8'ha6) ##2 1 |->
        supply_range_valid_q == ($past(wr_data[1:0], 2) != 2'h3)) else $error("valid wrong");
    a_two_word: assert property (s_wr(8'ha8) ##2 1 |->
        device_setup_two_q == $past(wr_data, 2)) else $error("setup two word wrong");
    a_two_rdback: assert property (s_wr(8'ha8) ##1 s_rd(8'ha8) |=>
        rd_data_q == $past(wr_data, 2)) else $error("setup two readback wrong");
    a_pin_rdback: assert property (s_wr(8'ha4) ##1 s_rd(8'ha4) |=>
        rd_data_q == $past(wr_data, 2)) else $error("pin setup readback wrong");
    a_unmapped_rd: assert property (rd_en && addr != 8'ha4 && addr != 8'ha6
        && addr != 8'ha8 |=> rd_data_q == 32'h0) else $error("unmapped read not zero");
    a_read_pulse: assert property (rd_data_q != 32'h0 |-> $past(rd_en))
        else $error("read data outside read cycle");
endmodule
bind hwpdc_config_regs hwpdc_regs_chk i_chk (.clk(clk), .reset(reset), .addr(addr),
    .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data_q(rd_data_q),
    .speed_sel_q(speed_sel_q), .target_addr_q(target_addr_q),
    .supply_range_select_q(supply_range_select_q),
    .supply_range_valid_q(supply_range_valid_q), .device_setup_two_q(device_setup_two_q));
`default_nettype wire

// ---- tb/tb.sv ----
`timescale 1ns/1ns
`default_nettype none
module tb;
    logic        clk = 1'b0;
    logic        reset = 1'b1;
    logic [7:0]  addr = 8'h00;
    logic [31:0] wr_data = 32'h0;
    logic        wr_en = 1'b0;
    logic        rd_en = 1'b0;
    logic        stored_load = 1'b0;
    logic [31:0] stored_data = 32'h0;
    logic        brake_pin = 1'b0;
    logic [2:0]  opt = 3'h0;
    logic [31:0] rd_data_q;
    logic        multi_out_q;
    logic [6:0]  target_addr_q;
    logic [1:0]  supply_range_select_q;
    logic        supply_range_valid_q;
    logic [31:0] device_setup_two_q;
    hwpdc_pkg::hwpdc_brake_ctl_t brake_ctl_q;
    hwpdc_pkg::hwpdc_speed_sel_t speed_sel_q;
    int          n_fail = 0;
    int          total_checks = 0;
    always #10 clk = ~clk;
    hwpdc_config_regs i_dut (.clk(clk), .reset(reset), .addr(addr), .wr_data(wr_data),
        .wr_en(wr_en), .rd_en(rd_en), .rd_data_q(rd_data_q), .stored_load(stored_load),
        .stored_data(stored_data), .brake_pin(brake_pin), .output_option_a(opt[0]),
        .output_option_b(opt[1]), .output_option_c(opt[2]), .multi_out_q(multi_out_q),
        .brake_ctl_q(brake_ctl_q), .speed_sel_q(speed_sel_q), .target_addr_q(target_addr_q),
        .supply_range_select_q(supply_range_select_q),
        .supply_range_valid_q(supply_range_valid_q), .device_setup_two_q(device_setup_two_q));
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wr_data <= d;
        wr_en <= 1'b1;
        @(posedge clk);
        wr_en <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge clk);
        rd_en <= 1'b0;
        #1 chk("read data", rd_data_q, exp);
    endtask
    // write then read the same place with no gap
    task automatic bb(input logic [7:0] a, input logic [31:0] d);
        wr(a, d);
        rd_en <= 1'b1;
        @(posedge clk);
        rd_en <= 1'b0;
        #1 chk("readback", rd_data_q, d);
    endtask
    task automatic settle();
        repeat (2) @(posedge clk);
        #1;
    endtask
    task automatic t_reset();
        @(posedge clk);
        reset <= 1'b1;
        repeat (20) @(posedge clk);
        reset <= 1'b0;
        rd(8'ha4, 32'h0);
        rd(8'ha6, 32'h0);
        rd(8'ha8, 32'h0);
        chk("speed", 32'(speed_sel_q), 32'h8);
        chk("valid", 32'(supply_range_valid_q), 32'h1);
        $display("test reset done");
    endtask
    task automatic brk(input logic [31:0] d, input logic p, input logic [2:0] e);
        wr(8'ha4, d);
        brake_pin <= p;
        #1;
        for (int i = 0; i < 12 && brake_ctl_q !== e; i++)
        begin
            @(posedge clk);
            #1;
        end
        chk("brake", 32'(brake_ctl_q), 32'(e));
        // a wait that ran out of its bound ends the run
        if (brake_ctl_q !== e)
            wrap_up();
    endtask
    task automatic t_mix();
        for (int i = 0; i < 4; i++)
        begin
            wr(8'ha4, 32'(i));
            settle();
            chk("speed", 32'(speed_sel_q), 32'h8 >> i);
        end
        brk(32'h04, 1'b0, 3'h4);
        brk(32'h24, 1'b0, 3'h2);
        brk(32'h34, 1'b0, 3'h3);
        brk(32'h0c, 1'b1, 3'h4);
        brk(32'h08, 1'b1, 3'h0);
        brk(32'h00, 1'b1, 3'h4);
        brk(32'h00, 1'b0, 3'h0);
        for (int p = 2; p < 8; p += 3)
            for (int s = 0; s < 4; s++)
            begin
                @(posedge clk);
                opt <= p[2:0];
                wr(8'ha6, 32'(s) << 28);
                settle();
                chk("multi", 32'(multi_out_q), 32'((s != 0) && opt[s - 1]));
            end
        $display("test pin modes done");
    endtask
    task automatic t_dev();
        logic [31:0] d;
        for (int i = 0; i < 4; i++)
        begin
            d = 32'h80000000 | (32'(8'h7f - i) << 20) | 32'(i);
            wr(8'ha6, d);
            settle();
            chk("target", 32'(target_addr_q), 32'(8'h7f - i));
            chk("range", 32'(supply_range_select_q), 32'(i));
            chk("valid", 32'(supply_range_valid_q), 32'(i != 3));
            rd(8'ha6, d);
        end
        wr(8'ha6, 32'h0);
        stored_data <= 32'hffffffff;
        stored_load <= 1'b1;
        @(posedge clk);
        stored_load <= 1'b0;
        rd(8'ha6, 32'h07ffffe0);
        bb(8'ha4, 32'hffffffff);
        bb(8'ha8, 32'ha5c3e1f7);
        settle();
        chk("setup two", device_setup_two_q, 32'ha5c3e1f7);
        wr(8'ha5, 32'hffffffff);
        rd(8'ha5, 32'h0);
        rd(8'ha4, 32'hffffffff);
        $display("test device setup done");
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    initial
    begin
        t_reset();
        t_mix();
        t_dev();
        t_reset();
        wrap_up();
    end
endmodule
`default_nettype wire
